// file: design/ctt_cont_tx_top.sv
// Behaviour
// (R1) Pseudo-random mode repeats PSDU bytes endlessly without SHR or PHR.
// (R2) Tone sits half a megahertz above or below centre, never on it.
// (R3) Host loads a buffer with at least a valid PHR before starting.
// (R4) Host preferably loads a 127-byte frame for pseudo-random mode.
// (R5) Host finishes channel, power and mode setup before enabling.
// (R6) Enable needs test field 0xF, buffer load, then 0x54, 0x46 to unlock.
// (R7) PLL-on command, wait for lock interrupt, then start command transmits.
// (R8) Host loads valid PSDU bytes even for tone mode.
// (R9) Lock interrupt sets status bit 0, gated by its enable bit.
// (R10) Off command enters the off state, which reads back as 0x08.
// (R11) Test field 0x0 means no test, 0xF means continuous transmission.
// (R12) Host writes raw data registers only for tone mode.
// (R13) All 0x00 gives the lower tone, all 0xFF the upper tone.
// (R14) Host preferably loads random maximum-length payload for mask tests.
// (R15) Host sets channel, power and clock output through their registers.
// (R16) Writing 0x00 to the unlock register stops continuous transmission.
// (R17) Test field 0x0 restores normal frames with SHR and PHR.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ctt_cont_tx_top
	import ctt_pkg::*;
#(
	parameter int BYTE_CYCLES     = BYTE_CYCLES_DEF,
	parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic             o_irq,
	output ctt_tx_s          o_tx,
	output logic             o_cw_active,
	output logic             o_cw_upper,
	output logic      [7:0]  o_channel,
	output logic      [7:0]  o_tx_power,
	output logic      [7:0]  o_clk_out_cfg
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [7:0]  state_cmd_reg;
	logic [7:0]  clk_out_reg;
	logic [7:0]  tx_ctrl_reg;
	logic [7:0]  tx_power_reg;
	logic [7:0]  channel_reg;
	logic [7:0]  raw_a_reg;
	logic [7:0]  raw_c_reg;
	logic [7:0]  unlock_reg;
	logic [7:0]  test_ctrl_reg;
	logic [7:0]  phr_reg;
	logic        unlock_step_reg;
	logic        cont_armed_reg;
	ctt_trx_e    state_reg;
	ctt_phase_e  phase_reg;
	logic [15:0] lock_cnt_reg;
	logic [15:0] pace_reg;
	logic [2:0]  shr_cnt_reg;
	logic [6:0]  tx_idx_reg;
	logic        tx_cont_reg;
	logic        pass_zero_reg;
	logic        pass_ones_reg;
	logic        cw_active_reg;
	logic        cw_upper_reg;
	ctt_tx_s     tx_reg;
	logic [7:0]  fb_rdata_a;
	logic [7:0]  fb_rdata_b;
	logic [7:0]  irq_status;
	logic [7:0]  irq_enable;

	wire logic [9:0] acc_idx    = i_paddr[11:2];
	wire logic [7:0] wdata8     = i_pwdata[7:0];
	wire logic       is_fb      = (acc_idx[9:7] == IDX_FB_BASE[9:7]);
	wire logic       access     = i_psel & i_penable;
	wire logic       wr_fire    = access & pready_reg & i_pwrite;
	wire logic       rd_capture = access & ~pready_reg & ~i_pwrite;
	wire logic       err_check  = access & ~pready_reg;

	function automatic logic wr_hit(input logic [9:0] idx);
		wr_hit = wr_fire && (acc_idx == idx);
	endfunction

	function automatic logic reg_mapped(input logic [9:0] idx);
		case (idx)
			IDX_TRX_STATUS, IDX_STATE_COMMAND_FIELD, IDX_CLK_OUT, IDX_TX_CTRL,
			IDX_TX_POWER, IDX_CHANNEL, IDX_RAW_A, IDX_RAW_C,
			IDX_IRQ_EN, IDX_IRQ_STATUS, IDX_UNLOCK, IDX_TEST_CTRL,
			IDX_IRQ_CLEAR: reg_mapped = 1'b1;
			default:       reg_mapped = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Status and mode decode
	// ------------------------------------------------------------
	wire logic [3:0] test_field = test_ctrl_reg[TEST_MSB:TEST_LSB];
	wire logic       cont_mode  = cont_armed_reg && (test_field == TEST_CONT);
	wire logic       raw_mode   = (raw_c_reg == RAW_C_ON) &&
	                              (raw_a_reg == RAW_A_ON);
	wire logic [7:0] status_code =
		(state_reg == ST_RADIO_OFF) ? STS_OFF :     // R10
		(state_reg == ST_PLL_ON)    ? STS_PLL_ON :
		(state_reg == ST_BUSY_TX)   ? STS_BUSY_TX : STS_IN_TRANS;

	wire logic [7:0] rd_val =
		is_fb                       ? fb_rdata_a :
		(acc_idx == IDX_TRX_STATUS) ? status_code :
		(acc_idx == IDX_STATE_COMMAND_FIELD)    ? state_cmd_reg :
		(acc_idx == IDX_CLK_OUT)    ? clk_out_reg :
		(acc_idx == IDX_TX_CTRL)    ? tx_ctrl_reg :
		(acc_idx == IDX_TX_POWER)   ? tx_power_reg :
		(acc_idx == IDX_CHANNEL)    ? channel_reg :
		(acc_idx == IDX_RAW_A)      ? raw_a_reg :
		(acc_idx == IDX_RAW_C)      ? raw_c_reg :
		(acc_idx == IDX_IRQ_EN)     ? irq_enable :
		(acc_idx == IDX_IRQ_STATUS) ? irq_status :
		(acc_idx == IDX_UNLOCK)     ? unlock_reg :
		(acc_idx == IDX_TEST_CTRL)  ? test_ctrl_reg : 8'h00;

	// Plain compares: an assign misses a function's hidden reads
	wire logic cmd_wr     = wr_fire && (acc_idx == IDX_STATE_COMMAND_FIELD);
	wire logic cmd_off    = cmd_wr && (wdata8 == CMD_OFF);      // R10
	wire logic cmd_pll    = cmd_wr && (wdata8 == CMD_PLL_ON);   // R7
	wire logic cmd_tx     = cmd_wr && (wdata8 == CMD_TX_START); // R7
	wire logic unlock_wr  = wr_fire && (acc_idx == IDX_UNLOCK);
	wire logic test_wr    = wr_fire && (acc_idx == IDX_TEST_CTRL);
	wire logic clr_wr     = wr_fire && (acc_idx == IDX_IRQ_CLEAR);
	wire logic en_wr      = wr_fire && (acc_idx == IDX_IRQ_EN);
	wire logic lock_done  = (state_reg == ST_LOCKING) &&
	                        (lock_cnt_reg == 16'(PLL_LOCK_CYCLES - 1));
	wire logic tick       = (state_reg == ST_BUSY_TX) &&
	                        (pace_reg == 16'(BYTE_CYCLES - 1));
	wire logic [6:0] psdu_len = (phr_reg[6:0] == 7'd0) ? 7'd1 : phr_reg[6:0];
	wire logic psdu_last  = (tx_idx_reg == psdu_len);
	wire logic in_psdu    = (phase_reg == PH_PSDU);
	wire logic norm_done  = tick && in_psdu && psdu_last && !tx_cont_reg;
	wire logic cont_stop  = (state_reg == ST_BUSY_TX) && tx_cont_reg &&
	                        !cont_mode;                          // R16
	wire logic start_tx   = (state_reg == ST_PLL_ON) && cmd_tx;  // R7
	wire logic shr_last   = (shr_cnt_reg == SHR_LAST);
	wire logic [7:0] tx_byte =
		(phase_reg == PH_SHR) ? (shr_last ? SFD_BYTE : PREAMBLE_BYTE) :
		(phase_reg == PH_PHR) ? {1'b0, psdu_len} : fb_rdata_b;
	wire logic first_b    = (tx_idx_reg == 7'd1);
	wire logic zero_now   = (first_b | pass_zero_reg) &&
	                        (fb_rdata_b == CW_LOW_BYTE);         // R13
	wire logic ones_now   = (first_b | pass_ones_reg) &&
	                        (fb_rdata_b == CW_HIGH_BYTE);        // R13
	wire logic [7:0] irq_set = (8'(lock_done) << IRQ_LOCK_BIT) |
	                           (8'(norm_done) << IRQ_END_BIT);   // R9

	// ------------------------------------------------------------
	// APB answer: one wait state, then pready
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= access & ~pready_reg;
			if (rd_capture) begin
				prdata_reg <= {24'h00_0000, rd_val};
			end
			if (err_check) begin
				pslverr_reg <= ~(is_fb | reg_mapped(acc_idx));
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_cmd_reg <= RST_STATE_COMMAND_FIELD;
			clk_out_reg   <= RST_CLK_OUT;
			tx_ctrl_reg   <= RST_TX_CTRL;
			tx_power_reg  <= RST_TX_POWER;
			channel_reg   <= RST_CHANNEL;
			raw_a_reg     <= RST_RAW_A;
			raw_c_reg     <= RST_RAW_C;
			unlock_reg    <= RST_UNLOCK;
			test_ctrl_reg <= RST_TEST_CTRL;
			phr_reg       <= 8'h00;
		end else begin
			if (cmd_wr) state_cmd_reg <= wdata8;
			if (wr_hit(IDX_CLK_OUT)) clk_out_reg <= wdata8;
			if (wr_hit(IDX_TX_CTRL)) tx_ctrl_reg <= wdata8;
			if (wr_hit(IDX_TX_POWER)) tx_power_reg <= wdata8;
			if (wr_hit(IDX_CHANNEL)) channel_reg <= wdata8;
			if (wr_hit(IDX_RAW_A)) raw_a_reg <= wdata8;
			if (wr_hit(IDX_RAW_C)) raw_c_reg <= wdata8;
			if (unlock_wr) unlock_reg <= wdata8;
			if (test_wr) test_ctrl_reg <= wdata8;
			// Shadow of buffer byte 0 avoids a read-port conflict
			if (wr_hit(IDX_FB_BASE)) phr_reg <= wdata8;
		end
	end

	// ------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			unlock_step_reg <= 1'b0;
			cont_armed_reg  <= 1'b0;
		end else if (test_wr &&
		             wdata8[TEST_MSB:TEST_LSB] != TEST_CONT) begin
			unlock_step_reg <= 1'b0; // R17
			cont_armed_reg  <= 1'b0; // R11
		end else if (unlock_wr) begin
			unlock_step_reg <= (wdata8 == KEY_STEP1) &&
			                   (test_field == TEST_CONT); // R6
			if (wdata8 == KEY_STEP2 && unlock_step_reg) begin
				cont_armed_reg <= 1'b1; // R6
			end else if (wdata8 == KEY_STOP) begin
				cont_armed_reg <= 1'b0; // R16
			end
		end
	end

	// ------------------------------------------------------------
	// Radio state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_reg    <= ST_RADIO_OFF;
			lock_cnt_reg <= 16'h0000;
			pace_reg     <= 16'h0000;
		end else begin
			lock_cnt_reg <= (state_reg == ST_LOCKING) ?
			                lock_cnt_reg + 16'h0001 : 16'h0000;
			pace_reg <= ((state_reg == ST_BUSY_TX) && !tick) ?
			            pace_reg + 16'h0001 : 16'h0000;
			case (state_reg)
				ST_RADIO_OFF: begin
					if (cmd_pll) state_reg <= ST_LOCKING; // R7
				end
				ST_LOCKING: begin
					if (cmd_off) state_reg <= ST_RADIO_OFF;
					else if (lock_done) state_reg <= ST_PLL_ON; // R7
				end
				ST_PLL_ON: begin
					if (cmd_off) state_reg <= ST_RADIO_OFF; // R10
					else if (cmd_tx) state_reg <= ST_BUSY_TX; // R7
				end
				ST_BUSY_TX: begin
					if (cmd_off) state_reg <= ST_RADIO_OFF;
					else if (norm_done || cont_stop) state_reg <= ST_PLL_ON;
				end
				default: state_reg <= ST_RADIO_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Byte sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			phase_reg   <= PH_IDLE;
			shr_cnt_reg <= 3'd0;
			tx_idx_reg  <= 7'd1;
			tx_cont_reg <= 1'b0;
			tx_reg      <= '0;
		end else begin
			tx_reg.strobe <= tick && (phase_reg != PH_IDLE);
			if (tick) tx_reg.data <= tx_byte;
			if (start_tx) begin
				tx_cont_reg <= cont_mode;
				phase_reg   <= cont_mode ? PH_PSDU : PH_SHR; // R1 R17
				shr_cnt_reg <= 3'd0;
				tx_idx_reg  <= 7'd1;
			end else if (state_reg != ST_BUSY_TX || cmd_off) begin
				phase_reg <= PH_IDLE;
			end else if (tick) begin
				case (phase_reg)
					PH_SHR: begin
						shr_cnt_reg <= shr_cnt_reg + 3'd1;
						if (shr_last) phase_reg <= PH_PHR; // R17
					end
					PH_PHR: begin
						phase_reg  <= PH_PSDU;
						tx_idx_reg <= 7'd1;
					end
					PH_PSDU: begin
						// Wrap straight back to byte 1 when repeating
						tx_idx_reg <= psdu_last ? 7'd1 : tx_idx_reg + 7'd1; // R1
						if (psdu_last && !tx_cont_reg) phase_reg <= PH_IDLE;
					end
					default: phase_reg <= PH_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Tone detection, judged once per whole pass
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || state_reg != ST_BUSY_TX || cmd_off || cont_stop) begin
			pass_zero_reg <= 1'b1;
			pass_ones_reg <= 1'b1;
			cw_active_reg <= 1'b0;
			cw_upper_reg  <= 1'b0;
		end else if (tick && in_psdu && tx_cont_reg) begin
			pass_zero_reg <= zero_now;
			pass_ones_reg <= ones_now;
			if (psdu_last) begin
				// Mixed content stays modulated, never a centre tone
				cw_active_reg <= raw_mode && (zero_now || ones_now); // R2
				cw_upper_reg  <= ones_now; // R13
			end
		end
	end

	// ------------------------------------------------------------
	// Instances and outputs
	// ------------------------------------------------------------
	ctt_fb_mem u_fb (
		.i_sys_clk (i_sys_clk),
		.i_we      (wr_fire & is_fb),
		.i_waddr   (acc_idx[FB_AW-1:0]),
		.i_wdata   (wdata8),
		.i_raddr_a (acc_idx[FB_AW-1:0]),
		.i_raddr_b (tx_idx_reg),
		.o_rdata_a (fb_rdata_a),
		.o_rdata_b (fb_rdata_b)
	);

	ctt_irq u_irq (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_set     (irq_set),
		.i_clr_we  (clr_wr),
		.i_clr     (wdata8),
		.i_en_we   (en_wr),
		.i_en      (wdata8),
		.o_status  (irq_status),
		.o_enable  (irq_enable),
		.o_irq     (o_irq)
	);

	assign o_prdata      = prdata_reg;
	assign o_pready      = pready_reg;
	assign o_pslverr     = pslverr_reg;
	assign o_tx          = tx_reg;
	assign o_cw_active   = cw_active_reg;
	assign o_cw_upper    = cw_upper_reg;
	assign o_channel     = channel_reg;
	assign o_tx_power    = tx_power_reg;
	assign o_clk_out_cfg = clk_out_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	AST_CONT_NO_HEADER: assert property ( // R1
		(tx_cont_reg && phase_reg != PH_IDLE) |-> phase_reg == PH_PSDU)
		else $error("continuous pass left PSDU phase");
	AST_CW_OFFSET: assert property ( // R2
		o_cw_active |-> raw_mode && tx_cont_reg && state_reg == ST_BUSY_TX)
		else $error("tone without raw continuous transmission");
	AST_UNLOCK: assert property ( // R6
		$rose(cont_armed_reg) |-> $past(unlock_wr && wdata8 == KEY_STEP2
		&& unlock_step_reg))
		else $error("armed without the unlock sequence");
	AST_START_AFTER_LOCK: assert property ( // R7
		$rose(state_reg == ST_BUSY_TX) |-> $past(state_reg == ST_PLL_ON))
		else $error("transmit entered without lock");
	AST_LOCK_IRQ: assert property ( // R9
		(state_reg == ST_LOCKING && lock_done) |=>
		state_reg == ST_PLL_ON && irq_status[IRQ_LOCK_BIT])
		else $error("lock did not raise its status bit");
	AST_OFF_READBACK: assert property ( // R10
		$past(cmd_off) |-> status_code == STS_OFF)
		else $error("off command not reflected in status");
	AST_TEST_FIELD: assert property ( // R11
		cont_armed_reg |-> test_field == TEST_CONT)
		else $error("armed with test field not 0xF");
	AST_CW_BYTES: assert property ( // R13
		$rose(o_cw_active) |-> o_tx.data == (o_cw_upper ? CW_HIGH_BYTE :
		CW_LOW_BYTE))
		else $error("tone side disagrees with buffer content");
	AST_STOP: assert property ( // R16
		(unlock_wr && wdata8 == KEY_STOP && state_reg == ST_BUSY_TX &&
		tx_cont_reg) |=> ##1 state_reg != ST_BUSY_TX)
		else $error("stop key did not end transmission");
	AST_NORMAL_SHR: assert property ( // R17
		(start_tx && !cont_mode) |=> phase_reg == PH_SHR [*2])
		else $error("normal frame skipped the header");

	COV_CONT_PASS: cover property (tick && in_psdu && psdu_last && tx_cont_reg);
	COV_CW_UPPER: cover property ($rose(o_cw_active) && o_cw_upper);
	COV_NORMAL_END: cover property (norm_done);
	COV_IRQ: cover property ($rose(o_irq));

endmodule
`default_nettype wire

// file: design/ctt_fb_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ctt_fb_mem
	import ctt_pkg::*;
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_we,
	input  wire logic [FB_AW-1:0] i_waddr,
	input  wire logic [7:0]       i_wdata,
	input  wire logic [FB_AW-1:0] i_raddr_a,
	input  wire logic [FB_AW-1:0] i_raddr_b,
	output logic      [7:0]       o_rdata_a,
	output logic      [7:0]       o_rdata_b
);

	// ------------------------------------------------------------
	// Storage, two registered read ports
	// ------------------------------------------------------------
	logic [7:0] mem [FB_DEPTH];

	always_ff @(posedge i_sys_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata_a <= mem[i_raddr_a];
		o_rdata_b <= mem[i_raddr_b];
	end

endmodule
`default_nettype wire

// file: design/ctt_irq.sv
`timescale 1ns/10ps
`default_nettype none
module ctt_irq
	import ctt_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_set,
	input  wire logic       i_clr_we,
	input  wire logic [7:0] i_clr,
	input  wire logic       i_en_we,
	input  wire logic [7:0] i_en,
	output logic      [7:0] o_status,
	output logic      [7:0] o_enable,
	output logic            o_irq
);

	// ------------------------------------------------------------
	// Sticky status, set wins over a clear in the same cycle
	// ------------------------------------------------------------
	wire logic [7:0] clr_mask    = i_clr_we ? i_clr : 8'h00;
	wire logic [7:0] status_next = (o_status & ~clr_mask) | i_set;
	wire logic [7:0] enable_next = i_en_we ? i_en : o_enable;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_status <= 8'h00;
			o_enable <= RST_IRQ_EN;
			o_irq    <= 1'b0;
		end else begin
			o_status <= status_next;
			o_enable <= enable_next;
			o_irq    <= |(status_next & enable_next);
		end
	end

endmodule
`default_nettype wire

// file: design/ctt_pkg.sv
package ctt_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ             = 250;
	localparam int BYTE_TIME_NS        = 32000;
	localparam int BYTE_CYCLES_DEF     = (BYTE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int PLL_LOCK_TIME_US    = 80;
	localparam int PLL_LOCK_CYCLES_DEF = PLL_LOCK_TIME_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_TRX_STATUS = 10'h001;
	localparam logic [9:0] IDX_STATE_COMMAND_FIELD    = 10'h002;
	localparam logic [9:0] IDX_CLK_OUT    = 10'h003;
	localparam logic [9:0] IDX_TX_CTRL    = 10'h004;
	localparam logic [9:0] IDX_TX_POWER   = 10'h005;
	localparam logic [9:0] IDX_CHANNEL    = 10'h008;
	localparam logic [9:0] IDX_RAW_A      = 10'h00A;
	localparam logic [9:0] IDX_RAW_C      = 10'h00C;
	localparam logic [9:0] IDX_IRQ_EN     = 10'h00E;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h00F;
	localparam logic [9:0] IDX_UNLOCK     = 10'h01C;
	localparam logic [9:0] IDX_TEST_CTRL  = 10'h036;
	localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h040;
	localparam logic [9:0] IDX_FB_BASE    = 10'h080;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_STATE_COMMAND_FIELD   = 8'h00;
	localparam logic [7:0] RST_CLK_OUT   = 8'h09;
	localparam logic [7:0] RST_TX_CTRL   = 8'h22;
	localparam logic [7:0] RST_TX_POWER  = 8'h00;
	localparam logic [7:0] RST_CHANNEL   = 8'h2B;
	localparam logic [7:0] RST_RAW_A     = 8'h37;
	localparam logic [7:0] RST_RAW_C     = 8'h20;
	localparam logic [7:0] RST_IRQ_EN    = 8'h00;
	localparam logic [7:0] RST_UNLOCK    = 8'h0B;
	localparam logic [7:0] RST_TEST_CTRL = 8'h00;

	// ------------------------------------------------------------
	// Commands, codes and fields
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_TX_START  = 8'h02;
	localparam logic [7:0] CMD_OFF       = 8'h03;
	localparam logic [7:0] CMD_PLL_ON    = 8'h09;
	localparam logic [7:0] STS_OFF       = 8'h08;
	localparam logic [7:0] STS_PLL_ON    = 8'h09;
	localparam logic [7:0] STS_BUSY_TX   = 8'h02;
	localparam logic [7:0] STS_IN_TRANS  = 8'h1F;
	localparam logic [7:0] KEY_STEP1     = 8'h54;
	localparam logic [7:0] KEY_STEP2     = 8'h46;
	localparam logic [7:0] KEY_STOP      = 8'h00;
	localparam int         TEST_LSB      = 0;
	localparam int         TEST_MSB      = 3;
	localparam logic [3:0] TEST_NONE     = 4'h0;
	localparam logic [3:0] TEST_CONT     = 4'hF;
	localparam logic [7:0] RAW_C_ON      = 8'h03;
	localparam logic [7:0] RAW_A_ON      = 8'h37;
	localparam int         IRQ_LOCK_BIT  = 0;
	localparam int         IRQ_END_BIT   = 3;
	localparam logic [2:0] SHR_LAST      = 3'd4;
	localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
	localparam logic [7:0] SFD_BYTE      = 8'hA7;
	localparam logic [7:0] CW_LOW_BYTE   = 8'h00;
	localparam logic [7:0] CW_HIGH_BYTE  = 8'hFF;
	localparam int         FB_DEPTH      = 128;
	localparam int         FB_AW         = 7;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RADIO_OFF = 4'b0001,
		ST_LOCKING   = 4'b0010,
		ST_PLL_ON    = 4'b0100,
		ST_BUSY_TX   = 4'b1000
	} ctt_trx_e;

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_SHR  = 4'b0010,
		PH_PHR  = 4'b0100,
		PH_PSDU = 4'b1000
	} ctt_phase_e;

	typedef struct packed {
		logic       strobe;
		logic [7:0] data;
	} ctt_tx_s;

endpackage

// file: dv/ctt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ctt_host_model (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [11:0] o_paddr,
	output logic      [31:0] o_pwdata
);
	// ------
	// Host bus side
	// ------
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0000_0000;
	end
	// Bounded wait, no fixed latency assumed
	task automatic xfer(input logic w, input logic [9:0] idx,
		input logic [7:0] d, output logic [7:0] rd, output logic err,
		output logic tmo);
		tmo = 1'b1;
		rd = 8'h00;
		err = 1'b0;
		@(posedge i_sys_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= {idx, 2'b00};
		o_pwdata <= {24'h00_0000, d};
		@(posedge i_sys_clk);
		o_penable <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(posedge i_sys_clk);
			if (i_pready === 1'b1) begin
				rd = i_prdata[7:0];
				err = i_pslverr;
				tmo = 1'b0;
				break;
			end
		end
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ctt_pkg::*;
	localparam int BC = 8;
	localparam int LC = 10;
	logic        clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	ctt_tx_s     tx;
	logic        cw_act;
	logic        cw_up;
	logic [7:0]  chan;
	logic [7:0]  pwr;
	logic [7:0]  clko;
	logic [7:0]  rd;
	logic        err;
	logic        tmo;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	// ------
	// Harness
	// ------
	ctt_cont_tx_top #(.BYTE_CYCLES(BC), .PLL_LOCK_CYCLES(LC)) dut (
		.i_sys_clk(clk), .i_srst(srst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .o_tx(tx),
		.o_cw_active(cw_act), .o_cw_upper(cw_up), .o_channel(chan),
		.o_tx_power(pwr), .o_clk_out_cfg(clko));
	ctt_host_model host (
		.i_sys_clk(clk), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
		.o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic fail(input string m);
		$display("[FAIL] %0t %s", $time, m);
		n_mismatch++;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string m);
		cmp_count++;
		if (g !== e)
			fail(m);
	endtask
	task automatic rw(input logic w, input logic [9:0] i,
		input logic [7:0] d);
		host.xfer(w, i, d, rd, err, tmo);
		if (tmo !== 1'b0) begin
			fail("bus timeout");
			summarize();
		end
	endtask
	task automatic rdc(input logic [9:0] i, input logic [7:0] e);
		rw(1'b0, i, 8'h00);
		chk(rd, e, "read");
	endtask
	task automatic nxt(input logic [7:0] e);
		for (int k = 0; k < 4 * BC; k++) begin
			@(posedge clk);
			if (tx.strobe === 1'b1) begin
				chk(tx.data, e, "tx byte");
				return;
			end
		end
		fail("no strobe");
		summarize();
	endtask
	// Polling status rather than a fixed wait: lock time is a parameter
	task automatic arm(input logic [7:0] b1, input logic [7:0] b2,
		input logic [6:0] len);
		rw(1'b1, IDX_TEST_CTRL, 8'h0F);
		rw(1'b1, IDX_FB_BASE, {1'b0, len});
		// Zero mask gives a flat tone buffer, all ones a varied payload
		for (int k = 1; k <= len; k++)
			rw(1'b1, IDX_FB_BASE + 10'(k), b1 ^ (b2 & 8'(k * 37)));
		rw(1'b1, IDX_UNLOCK, KEY_STEP1);
		rw(1'b1, IDX_UNLOCK, KEY_STEP2);
		rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_PLL_ON);
		for (int k = 0; k < 40; k++) begin
			rw(1'b0, IDX_TRX_STATUS, 8'h00);
			if (rd === STS_PLL_ON)
				return;
		end
		fail("no lock");
		summarize();
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_regs();
		rdc(IDX_TEST_CTRL, RST_TEST_CTRL);
		rw(1'b0, 10'h3FF, 8'h00);
		chk({7'h00, err}, 8'h01, "unmapped");
		rw(1'b1, IDX_IRQ_EN, 8'h01);
		rw(1'b1, IDX_TX_CTRL, 8'h00);
		rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_OFF);
		rdc(IDX_TRX_STATUS, STS_OFF);
		rw(1'b1, IDX_CLK_OUT, 8'h01);
		rw(1'b1, IDX_CHANNEL, 8'h33);
		rw(1'b1, IDX_TX_POWER, 8'h0C);
		rdc(IDX_CHANNEL, 8'h33);
		chk(chan, 8'h33, "channel out");
		chk(pwr, 8'h0C, "power out");
		chk(clko, 8'h01, "clock out");
		$display("t_regs done");
	endtask
	task automatic t_prbs();
		arm(8'h5A, 8'hFF, 7'd127);
		@(posedge clk);
		chk({7'h00, irq}, 8'h01, "irq");
		rdc(IDX_IRQ_STATUS, 8'h01);
		rw(1'b1, IDX_IRQ_CLEAR, 8'h01);
		rdc(IDX_IRQ_STATUS, 8'h00);
		chk({7'h00, irq}, 8'h00, "irq clear");
		rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_TX_START);
		for (int k = 0; k < 130; k++)
			nxt(8'h5A ^ 8'((k % 127 + 1) * 37));
		rdc(IDX_TRX_STATUS, STS_BUSY_TX);
		rw(1'b1, IDX_UNLOCK, KEY_STOP);
		rdc(IDX_TRX_STATUS, STS_PLL_ON);
		$display("t_prbs done");
	endtask
	task automatic t_cw();
		rw(1'b1, IDX_RAW_C, RAW_C_ON);
		rw(1'b1, IDX_RAW_A, RAW_A_ON);
		rw(1'b1, IDX_IRQ_EN, 8'h00);
		for (int u = 0; u < 2; u++) begin
			rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_OFF);
			arm({8{u[0]}}, 8'h00, 7'd2);
			@(posedge clk);
			chk({7'h00, irq}, 8'h00, "masked");
			rdc(IDX_IRQ_STATUS, 8'h01);
			rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_TX_START);
			for (int k = 0; k < 5; k++)
				nxt({8{u[0]}});
			chk({6'h00, cw_act, cw_up}, {7'h01, u[0]}, "tone");
			rw(1'b1, IDX_UNLOCK, KEY_STOP);
		end
		rdc(IDX_TRX_STATUS, STS_PLL_ON);
		chk({6'h00, cw_act, cw_up}, 8'h00, "tone off");
		$display("t_cw done");
	endtask
	task automatic t_norm();
		rw(1'b1, IDX_TEST_CTRL, 8'h00);
		rw(1'b1, IDX_FB_BASE, 8'h01);
		rw(1'b1, IDX_FB_BASE + 10'h001, 8'hC3);
		rw(1'b1, IDX_IRQ_CLEAR, 8'hFF);
		rw(1'b1, IDX_STATE_COMMAND_FIELD, CMD_TX_START);
		for (int k = 0; k < 4; k++)
			nxt(PREAMBLE_BYTE);
		nxt(SFD_BYTE);
		nxt(8'h01);
		nxt(8'hC3);
		rdc(IDX_TRX_STATUS, STS_PLL_ON);
		rdc(IDX_IRQ_STATUS, 8'h08);
		$display("t_norm done");
	endtask
	initial begin
		srst = 1'b1;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_prbs();
		t_cw();
		t_norm();
		summarize();
	end
endmodule
`default_nettype wire
